/* File: logic/trit_encoder_pkg.sv */
// Shared constants and types for the tri-state code serial encoder.
// Assumes a single 250 MHz system clock and pad cells that report each
// tri-state input as a floating flag plus a driven level.
package trit_encoder_pkg;

  // ----------------------------------------------------------------
  // Packet shape
  // ----------------------------------------------------------------
  localparam int CODE_LINES      = 10;
  localparam int DATA_LINES      = 8;
  localparam int WORDS_PER_CYCLE = 3;
  localparam int TRITS_PER_WORD  = CODE_LINES + DATA_LINES;
  localparam int SUBBITS_PER_WORD = 2 * TRITS_PER_WORD;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 250_000_000;
  localparam int ENC_OSC_HZ     = 70_000;
  // One slot is one period of the encoder oscillator, rounded down.
  localparam int SLOT_CYC       = CLK_HZ / ENC_OSC_HZ;
  localparam int PILOT_SLOTS    = 16;
  localparam int SLOTS_PER_SUB  = 4;
  localparam int MAX_LAG_MS     = 150;

  // ----------------------------------------------------------------
  // Sub-bit pairs sent for each input state
  // ----------------------------------------------------------------
  localparam logic [1:0] PAIR_LOW   = 2'h0;
  localparam logic [1:0] PAIR_HIGH  = 2'h3;
  localparam logic [1:0] PAIR_FLOAT = 2'h1;

  localparam logic RF_IDLE_LEVEL = 1'b0;

  // Tri-state pin as seen from its pad sense cell.
  typedef struct packed {
    logic floating;
    logic level;
  } trit_pin_t;

  typedef enum {
    ST_IDLE,
    ST_PILOT,
    ST_SYMBOL
  } enc_state_t;

endpackage

/* File: logic/tristate_code_serial_encoder.sv */
// Serial encoder that frames tri-state code-select and data inputs into
// repeated three-word packets for an RF modulator.
// Assumes all inputs are asynchronous pins and that the pad cells already
// tell a floating pin from a driven one.
//
// Contract
// RL1 - On request rise, capture inputs, build one packet, send it three times.
// RL2 - Each cycle is three words; cycles continue until request goes low.
// RL3 - A new cycle starts right after the last while request stays high.
// RL4 - After request falls, finish the running cycle, then stop output.
// RL5 - Packet: 10 code bits then 8 data bits, lowest line first.
// RL6 - High, low and floating inputs are all distinct and valid.
// RL7 - Receiver reads a floating data input as low.
// RL8 - Receiver accepts only on exact code match including floating.
// RL9 - Receiver ignores mismatched code and keeps its outputs.
// RL10 - On match, receiver mirrors the captured data states.
// RL11 - Data inputs are sampled again at the start of every cycle.
// RL12 - A data change is sent within 150 ms, after the running cycle.
// RL13 - While idle the modulation output stays at its inactive level.
`timescale 1ns/1ns

module tristate_code_serial_encoder #(
  parameter int SLOT_CYCLES = trit_encoder_pkg::SLOT_CYC
) (
  input  wire logic                          clk_sys_i,
  input  wire logic                          resetn_i,
  input  wire logic                          send_request_i,
  input  wire trit_encoder_pkg::trit_pin_t [trit_encoder_pkg::CODE_LINES-1:0]
                                             code_select_lines_i,
  input  wire trit_encoder_pkg::trit_pin_t [trit_encoder_pkg::DATA_LINES-1:0]
                                             input_bits_i,
  output logic                               rf_output_o,
  output logic                               transmitting_o
);

  localparam int NTRIT = trit_encoder_pkg::TRITS_PER_WORD;
  localparam int NSUB  = trit_encoder_pkg::SUBBITS_PER_WORD;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Every pin passes two flops; the first stage feeds only the second.
  logic                                 req_meta_reg;
  logic                                 req_sync_reg;
  trit_encoder_pkg::trit_pin_t [NTRIT-1:0] pins_meta_reg;
  trit_encoder_pkg::trit_pin_t [NTRIT-1:0] pins_sync_reg;
  trit_encoder_pkg::trit_pin_t [NTRIT-1:0] pins_raw;

  // RL5 - serial order
  assign pins_raw = {input_bits_i, code_select_lines_i};

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      req_meta_reg  <= 1'b0;
      req_sync_reg  <= 1'b0;
      pins_meta_reg <= '0;
      pins_sync_reg <= '0;
    end else begin
      req_meta_reg  <= send_request_i;
      req_sync_reg  <= req_meta_reg;
      pins_meta_reg <= pins_raw;
      pins_sync_reg <= pins_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Tri-state to sub-bit mapping
  // ----------------------------------------------------------------
  logic [NSUB-1:0] frame_bits;

  genvar gi;
  generate
    for (gi = 0; gi < NTRIT; gi++) begin : g_trit
      // RL6 - three distinct states
      assign frame_bits[2*gi +: 2] =
        pins_sync_reg[gi].floating ? trit_encoder_pkg::PAIR_FLOAT :
        pins_sync_reg[gi].level    ? trit_encoder_pkg::PAIR_HIGH  :
                                     trit_encoder_pkg::PAIR_LOW;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Slot timebase
  // ----------------------------------------------------------------
  // The timebase is held while idle so every word starts on a full slot.
  logic [15:0]                  slot_cnt_reg;
  logic                         slot_tick;
  trit_encoder_pkg::enc_state_t state_reg;

  assign slot_tick = (slot_cnt_reg == 16'(SLOT_CYCLES - 1));

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || state_reg == trit_encoder_pkg::ST_IDLE || slot_tick) begin
      slot_cnt_reg <= 16'h0000;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Framing state machine
  // ----------------------------------------------------------------
  logic [NSUB-1:0]              frame_reg;
  logic [NSUB-1:0]              frame_next;
  logic [4:0]                   slot_idx_reg;
  logic [4:0]                   slot_idx_next;
  logic [5:0]                   sub_idx_reg;
  logic [5:0]                   sub_idx_next;
  logic [1:0]                   word_reg;
  logic [1:0]                   word_next;
  trit_encoder_pkg::enc_state_t state_next;

  logic pilot_done;
  logic sub_done;
  logic word_done;
  logic cycle_done;

  assign pilot_done = slot_tick &&
                      (slot_idx_reg == 5'(trit_encoder_pkg::PILOT_SLOTS - 1));
  assign sub_done   = slot_tick &&
                      (slot_idx_reg == 5'(trit_encoder_pkg::SLOTS_PER_SUB - 1));
  assign word_done  = sub_done && (sub_idx_reg == 6'(NSUB - 1));
  // RL2 - three words per cycle
  assign cycle_done = word_done &&
                      (word_reg == 2'(trit_encoder_pkg::WORDS_PER_CYCLE - 1));

  always_comb begin
    state_next    = state_reg;
    frame_next    = frame_reg;
    slot_idx_next = slot_idx_reg;
    sub_idx_next  = sub_idx_reg;
    word_next     = word_reg;
    case (state_reg)
      trit_encoder_pkg::ST_IDLE: begin
        // RL1 - capture and start
        if (req_sync_reg) begin
          frame_next    = frame_bits;
          state_next    = trit_encoder_pkg::ST_PILOT;
          slot_idx_next = 5'h00;
          sub_idx_next  = 6'h00;
          word_next     = 2'h0;
        end
      end
      trit_encoder_pkg::ST_PILOT: begin
        if (pilot_done) begin
          state_next    = trit_encoder_pkg::ST_SYMBOL;
          slot_idx_next = 5'h00;
        end else if (slot_tick) begin
          slot_idx_next = slot_idx_reg + 5'h01;
        end
      end
      trit_encoder_pkg::ST_SYMBOL: begin
        if (cycle_done) begin
          slot_idx_next = 5'h00;
          sub_idx_next  = 6'h00;
          word_next     = 2'h0;
          // RL3 - back to back cycles
          // RL11 - fresh sample per cycle
          // RL12 - lag bounded by cycle
          if (req_sync_reg) begin
            frame_next = frame_bits;
            state_next = trit_encoder_pkg::ST_PILOT;
          // RL4 - stop only at cycle end
          end else begin
            state_next = trit_encoder_pkg::ST_IDLE;
          end
        end else if (word_done) begin
          // RL1 - same packet repeated
          state_next    = trit_encoder_pkg::ST_PILOT;
          slot_idx_next = 5'h00;
          sub_idx_next  = 6'h00;
          word_next     = word_reg + 2'h1;
        end else if (sub_done) begin
          slot_idx_next = 5'h00;
          sub_idx_next  = sub_idx_reg + 6'h01;
        end else if (slot_tick) begin
          slot_idx_next = slot_idx_reg + 5'h01;
        end
      end
      default: begin
        state_next = trit_encoder_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_reg    <= trit_encoder_pkg::ST_IDLE;
      frame_reg    <= '0;
      slot_idx_reg <= 5'h00;
      sub_idx_reg  <= 6'h00;
      word_reg     <= 2'h0;
    end else begin
      state_reg    <= state_next;
      frame_reg    <= frame_next;
      slot_idx_reg <= slot_idx_next;
      sub_idx_reg  <= sub_idx_next;
      word_reg     <= word_next;
    end
  end

  // ----------------------------------------------------------------
  // Modulation output
  // ----------------------------------------------------------------
  // A sub-bit is a slot high, two slots carrying the bit, then a slot low,
  // so the receiver always finds a rising edge to resync on.
  logic cur_sub;
  logic rf_level;

  assign cur_sub  = frame_reg[sub_idx_reg];
  assign rf_level = (state_reg != trit_encoder_pkg::ST_SYMBOL) ?
                      trit_encoder_pkg::RF_IDLE_LEVEL :
                    (slot_idx_reg == 5'h00) ? 1'b1 :
                    (slot_idx_reg == 5'(trit_encoder_pkg::SLOTS_PER_SUB - 1)) ? 1'b0 :
                    cur_sub;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rf_output_o    <= trit_encoder_pkg::RF_IDLE_LEVEL;
      transmitting_o <= 1'b0;
    end else begin
      // RL13 - quiet when idle
      rf_output_o    <= rf_level;
      transmitting_o <= (state_reg != trit_encoder_pkg::ST_IDLE);
    end
  end

endmodule

/* File: bench/tsce_props.sv */
// Port checker for the tri-state code serial encoder.
// Assumes one clock, a synchronous active-low reset and the bind below.
`timescale 1ns/1ns
module tsce_props #(
  parameter int SLOT_CYCLES = 4
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic send_request_i,
  input wire logic rf_output_o,
  input wire logic transmitting_o
);
  localparam int S = SLOT_CYCLES;
  localparam int PD = 16 * S - 1;
  localparam int CYC = 480 * S;
  int hi = 0;
  int lo = 0;
  int tc = 0;
  // Run lengths let the slot figures be checked without long repetitions.
  always_ff @(posedge clk_sys_i) begin
    hi <= rf_output_o ? hi + 1 : 0;
    lo <= (rf_output_o || !transmitting_o) ? 0 : lo + 1;
    tc <= transmitting_o ? tc + 1 : 0;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  chk_idle_rf_low:
  assert property (!transmitting_o |-> !rf_output_o)
    else $error("rf active while idle");
  chk_pilot_start:
  assert property ($rose(transmitting_o) |-> (!rf_output_o throughout ##PD 1'b1) ##1 rf_output_o)
    else $error("pilot length wrong");
  chk_high_run:
  assert property ($fell(rf_output_o) |-> hi == S || hi == 3 * S)
    else $error("high pulse length wrong");
  chk_low_run:
  assert property ($rose(rf_output_o) |-> lo inside {S, 3 * S, 16 * S, 17 * S, 19 * S})
    else $error("low gap length wrong");
  chk_cycle_len:
  assert property ($fell(transmitting_o) |-> tc > 0 && tc % CYC == 0)
    else $error("cycle truncated or stretched");
  chk_req_start:
  assert property ($rose(send_request_i) && !transmitting_o |-> ##[2:4] transmitting_o)
    else $error("request not taken");
  chk_idle_stays:
  assert property (!transmitting_o && !send_request_i && !$past(send_request_i)
    && !$past(send_request_i, 2) && !$past(send_request_i, 3) |=> !transmitting_o)
    else $error("cycle without request");
  chk_repeat_end:
  assert property ($fell(transmitting_o) |-> !$past(send_request_i, 3)
    || !$past(send_request_i, 4))
    else $error("stopped while request high");
endmodule
bind tristate_code_serial_encoder tsce_props #(.SLOT_CYCLES(SLOT_CYCLES)) tsce_props_i (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .send_request_i(send_request_i),
  .rf_output_o(rf_output_o), .transmitting_o(transmitting_o));

/* File: bench/rx_model.sv */
// Behavioural receiver and decoder for the encoder's serial stream.
// Assumes rf_i idles low and one slot lasts SLOT_CYCLES clocks.
`timescale 1ns/1ns
module rx_model #(
  parameter int SLOT_CYCLES = 4
) (
  input  wire logic                                clk_i,
  input  wire logic                                rf_i,
  input  wire trit_encoder_pkg::trit_pin_t [9:0]   local_code_i,
  output logic                             [7:0]   data_o,
  output logic                             [35:0]  word_o,
  output int                                       words_o
);
  int gap = 1000;
  int idx = 0;
  logic rf_q = 1'b0;
  logic ok;
  logic [35:0] sub;
  function automatic logic [1:0] pr(trit_encoder_pkg::trit_pin_t t);
    // A floating line is sent as a one followed by a zero.
    return t.floating ? 2'b01 : {2{t.level}};
  endfunction
  initial data_o = 8'h00;
  initial words_o = 0;
  // Sampling on the falling edge keeps clear of the register update.
  always @(negedge clk_i) begin
    if (rf_i && !rf_q) begin
      if (gap > 8 * SLOT_CYCLES) idx = 0;
      gap = 0;
    end else gap = gap + 1;
    rf_q = rf_i;
    if (gap == SLOT_CYCLES + SLOT_CYCLES / 2 && idx < 36) begin
      sub[idx] = rf_i;
      idx = idx + 1;
      if (idx == 36) begin
        ok = 1'b1;
        for (int i = 0; i < 10; i++) ok = ok && sub[2*i +: 2] == pr(local_code_i[i]);
        for (int i = 0; i < 8; i++) if (ok) data_o[i] = sub[20+2*i +: 2] == 2'b11;
        word_o = sub;
        words_o = words_o + 1;
      end
    end
  end
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the tri-state code serial encoder.
// Assumes the checker binds itself and rx_model decodes rf_output_o.
`timescale 1ns/1ns
module tb_top;
  localparam int S = 4;
  localparam int CYC = 480 * S;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic send_request_i = 1'b0;
  trit_encoder_pkg::trit_pin_t [9:0] code = '0;
  trit_encoder_pkg::trit_pin_t [9:0] local_code = '0;
  trit_encoder_pkg::trit_pin_t [7:0] data = '0;
  logic rf_output_o;
  logic transmitting_o;
  logic [7:0] rx_data;
  logic [7:0] prev;
  logic [35:0] rx_word;
  int rx_words;
  int w0;
  int fail_count = 0;
  int checked = 0;
  logic [31:0] lfsr = 32'h44d3bf07;
  always #2 clk_sys_i = ~clk_sys_i;
  tristate_code_serial_encoder #(.SLOT_CYCLES(S)) tristate_code_serial_encoder_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .send_request_i(send_request_i),
    .code_select_lines_i(code), .input_bits_i(data), .rf_output_o(rf_output_o),
    .transmitting_o(transmitting_o));
  rx_model #(.SLOT_CYCLES(S)) rx_model_i (.clk_i(clk_sys_i), .rf_i(rf_output_o),
    .local_code_i(local_code), .data_o(rx_data), .word_o(rx_word), .words_o(rx_words));
  function automatic trit_encoder_pkg::trit_pin_t rnd_trit();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return {lfsr[1] & lfsr[0], lfsr[2]};
  endfunction
  function automatic logic [1:0] pr(trit_encoder_pkg::trit_pin_t t);
    return t.floating ? 2'b01 : {2{t.level}};
  endfunction
  function automatic logic [35:0] exp_word();
    for (int i = 0; i < 18; i++) exp_word[2*i +: 2] = pr(i < 10 ? code[i] : data[i-10]);
  endfunction
  function automatic logic [7:0] exp_data();
    for (int i = 0; i < 8; i++) exp_data[i] = !data[i].floating && data[i].level;
  endfunction
  task automatic cmp(string n, logic [35:0] e, logic [35:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("Mismatches %0d of %0d comparisons", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Data changes mid-cycle at step chg, so only the next cycle may carry it.
  task automatic send(int hold, int chg);
    @(negedge clk_sys_i) send_request_i = 1'b1;
    for (int n = 0; n < hold; n++) begin
      @(negedge clk_sys_i);
      if (n == chg) for (int i = 0; i < 8; i++) data[i] = rnd_trit();
    end
    send_request_i = 1'b0;
    for (int n = 0; n < 4 * CYC && (transmitting_o !== 1'b0 || n < 8); n++)
      @(negedge clk_sys_i);
  endtask
  initial begin
    #(30 * CYC * 4);
    fail_count++;
    close_out();
  end
  initial begin
    repeat (16) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 10; i++) code[i] = rnd_trit();
      for (int i = 0; i < 8; i++) data[i] = rnd_trit();
      if (k == 0) data = 16'haaaa;
      local_code = code;
      if (k == 3) local_code[9].floating = !code[9].floating;
      w0 = rx_words;
      prev = rx_data;
      send(k == 2 ? CYC + 300 : 5, 300);
      cmp("words", 36'(k == 2 ? 6 : 3), 36'(rx_words - w0));
      cmp("word", exp_word(), rx_word);
      cmp("data", {28'h0, k == 3 ? prev : exp_data()}, {28'h0, rx_data});
      cmp("idle", 36'h0, {34'h0, transmitting_o, rf_output_o});
    end
    close_out();
  end
endmodule
